// ===== qsm_port.sv
// Purpose: Device side of a quad serial memory port with APB registers.
// Assumes: Serial clock is oversampled by clk_sys; mode 0 framing.
// Notes:   Pins pass two flops, so usable link rates are far below the
//          documented maxima; the overspeed flag reports what it can see.
//
// Local design decisions: the APB register port and the address map.

`timescale 1ns/100ps
`default_nettype none

// What this block does
// - SDR transfers up to 108 MHz.
// - DDR only for special opcodes, up to 54 MHz.
// - Lane option chosen by opcode or configuration.
// - Single mode: lane 0 is input only.
// - Dual/quad: lane 0 bidirectional, lowest lane.
// - Single mode: lane 1 drives output data.
// - Dual/quad: lane 1 bidirectional.
// - Single/dual: lane 2 is write protect input.
// - Quad: lane 2 is data, no protect.
// - Single/dual: lane 3 is hardware reset.
// - Quad: lane 3 is data, no reset.
// - Quad enable bit frees lanes 2 and 3.
// - Mode bits persist until overwritten.
// - Opcode phase always single data rate.
module qsm_port (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic [3:0]  laneIn,
    output var  logic [3:0]  laneOut,
    output var  logic [3:0]  laneOeN
);

    // =====================================================================
    // Helper functions
    // =====================================================================
    // Shift one edge's worth of lane bits into a byte, lane 0 lowest
    function automatic logic [7:0] putChunk(input logic [7:0] b,
                                            input logic [3:0] l,
                                            input qsm_pkg::qsm_width_t w);
        case (w)
            qsm_pkg::W2: putChunk = {b[5:0], l[1:0]};
            qsm_pkg::W4: putChunk = {b[3:0], l[3:0]};
            default:     putChunk = {b[6:0], l[0]};
        endcase
    endfunction

    // Top bits of a byte placed on the lanes; single mode uses lane 1
    // single output lane
    function automatic logic [3:0] getChunk(input logic [7:0] b,
                                            input qsm_pkg::qsm_width_t w);
        case (w)
            qsm_pkg::W2: getChunk = {2'h0, b[7:6]};
            qsm_pkg::W4: getChunk = b[7:4];
            default:     getChunk = {2'h0, b[7], 1'b0};
        endcase
    endfunction

    // Opcode to data phase shape
    function automatic qsm_pkg::qsm_cmd_t decodeCmd(
        input logic [7:0] op, input qsm_pkg::qsm_width_t ifw,
        input logic qp);
        decodeCmd = '0;
        decodeCmd.width = ifw;
        if (ifw == qsm_pkg::W1)
        begin
            // Extended options take their width from the opcode
            case (op)
                qsm_pkg::OP_READ:  decodeCmd.ok = 1'b1;
                qsm_pkg::OP_WRITE: decodeCmd.ok = 1'b1;
                qsm_pkg::OP_DUAL_RD:
                begin
                    decodeCmd.ok    = 1'b1;
                    decodeCmd.width = qsm_pkg::W2;
                end
                qsm_pkg::OP_QUAD_RD, qsm_pkg::OP_QUAD_WR:
                begin
                    decodeCmd.ok    = qp;
                    decodeCmd.width = qsm_pkg::W4;
                end
                default: decodeCmd.ok = 1'b0;
            endcase
        end
        else
        begin
            case (op)
                qsm_pkg::OP_READ, qsm_pkg::OP_WRITE: decodeCmd.ok = 1'b1;
                qsm_pkg::OP_DDR_RD, qsm_pkg::OP_DDR_WR:
                begin
                    decodeCmd.ok  = (ifw == qsm_pkg::W4);
                    decodeCmd.ddr = 1'b1;
                end
                default: decodeCmd.ok = 1'b0;
            endcase
        end
        decodeCmd.rd = (op == qsm_pkg::OP_READ) ||
                       (op == qsm_pkg::OP_DUAL_RD) ||
                       (op == qsm_pkg::OP_QUAD_RD) ||
                       (op == qsm_pkg::OP_DDR_RD);
    endfunction

    // =====================================================================
    // Pin sampling
    // =====================================================================
    qsm_pkg::qsm_pins_t  pinsRaw;
    qsm_pkg::qsm_pins_t  pinsSync;
    qsm_pkg::qsm_state_t state_q;
    qsm_pkg::qsm_width_t width_q;
    qsm_pkg::qsm_width_t ifWidth;
    qsm_pkg::qsm_cmd_t   cmdNext;
    logic                sclkPrev_q;
    logic                sclkRise;
    logic                sclkFall;
    logic [7:0]          cfg1_q;
    logic [7:0]          cfg2_q;
    logic [7:0]          txByte_q;
    logic [7:0]          rxByte_q;
    logic [7:0]          shift_q;
    logic [7:0]          shiftNext;
    logic [3:0]          bitCnt_q;
    logic [3:0]          cntNext;
    logic [3:0]          period_q;
    logic                ddr_q;
    logic                overspeed_q;
    logic                quadPins;
    logic                hwReset;
    logic                wpActive;
    logic                inEdge;
    logic                outEdge;
    logic                byteDone;
    logic                apbWrite;
    logic                err_q;
    logic [31:0]         rdData;

    assign pinsRaw = {sclk, csN, laneIn};

    qsm_sync #(
        .W ($bits(qsm_pkg::qsm_pins_t))
    ) uSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (pinsRaw),
        .q       (pinsSync)
    );

    // Serial clock edges seen in the system domain
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sclkPrev_q <= 1'b0;
        else
            sclkPrev_q <= pinsSync.sclk;
    end

    assign sclkRise = pinsSync.sclk & ~sclkPrev_q;
    assign sclkFall = ~pinsSync.sclk & sclkPrev_q;

    // =====================================================================
    // Pin function selection
    // =====================================================================
    // quad enable frees lanes
    assign quadPins = cfg1_q[qsm_pkg::CFG1_QUAD_EN] |
                      cfg2_q[qsm_pkg::CFG2_QUAD];
    assign ifWidth  = cfg2_q[qsm_pkg::CFG2_QUAD] ? qsm_pkg::W4 :
                      cfg2_q[qsm_pkg::CFG2_DUAL] ? qsm_pkg::W2 : qsm_pkg::W1;
    assign hwReset  = ~quadPins & ~pinsSync.lanes[3];
    assign wpActive = ~quadPins & ~pinsSync.lanes[2];

    // Sampling edge, and for DDR both edges after the opcode
    // opcode sampled on rise only
    assign inEdge    = sclkRise | (ddr_q & sclkFall);
    assign outEdge   = sclkFall | (ddr_q & sclkRise);
    assign shiftNext = putChunk(shift_q, pinsSync.lanes, width_q);
    assign cntNext   = bitCnt_q + {1'b0, width_q};
    assign byteDone  = (cntNext == qsm_pkg::BYTE_BITS);
    assign cmdNext   = decodeCmd(shiftNext, width_q, quadPins);

    // =====================================================================
    // Frame sequencer
    // =====================================================================
    // Chip select high or the reset pin ends any frame at once
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q  <= qsm_pkg::ST_IDLE;
            width_q  <= qsm_pkg::W1;
            ddr_q    <= 1'b0;
            bitCnt_q <= 4'h0;
            shift_q  <= qsm_pkg::BYTE_RST;
        end
        else if (hwReset || pinsSync.csN)
        begin
            state_q <= qsm_pkg::ST_IDLE;
            ddr_q   <= 1'b0;
        end
        else
        begin
            case (state_q)
                qsm_pkg::ST_IDLE:
                begin
                    state_q  <= qsm_pkg::ST_OPC;
                    width_q  <= ifWidth;
                    ddr_q    <= 1'b0;
                    bitCnt_q <= 4'h0;
                    shift_q  <= qsm_pkg::BYTE_RST;
                end
                qsm_pkg::ST_OPC:
                begin
                    if (sclkRise && byteDone)
                    begin
                        bitCnt_q <= 4'h0;
                        width_q  <= cmdNext.width;
                        ddr_q    <= cmdNext.ddr;
                        shift_q  <= txByte_q;
                        if (!cmdNext.ok)
                            state_q <= qsm_pkg::ST_SKIP;
                        else if (cmdNext.rd)
                            state_q <= qsm_pkg::ST_TX;
                        else
                            state_q <= qsm_pkg::ST_RX;
                    end
                    else if (sclkRise)
                    begin
                        bitCnt_q <= cntNext;
                        shift_q  <= shiftNext;
                    end
                end
                qsm_pkg::ST_RX:
                begin
                    if (inEdge)
                    begin
                        bitCnt_q <= byteDone ? 4'h0 : cntNext;
                        shift_q  <= shiftNext;
                    end
                end
                qsm_pkg::ST_TX:
                begin
                    // Each byte is reloaded from the transmit register
                    if (outEdge)
                    begin
                        bitCnt_q <= byteDone ? 4'h0 : cntNext;
                        shift_q  <= byteDone ? txByte_q : (shift_q << width_q);
                    end
                end
                qsm_pkg::ST_SKIP:
                    state_q <= qsm_pkg::ST_SKIP;
                default:
                    state_q <= qsm_pkg::ST_IDLE;
            endcase
        end
    end

    // Received bytes land here unless write protect is held low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rxByte_q <= qsm_pkg::BYTE_RST;
        else if (state_q == qsm_pkg::ST_RX && inEdge && byteDone &&
                 !wpActive && !pinsSync.csN && !hwReset)
            rxByte_q <= shiftNext;
    end

    // SDR output lanes change on the falling edge so the host samples on rise; DDR uses both edges
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            laneOut <= 4'h0;
        else if (state_q == qsm_pkg::ST_TX && outEdge)
            laneOut <= getChunk(shift_q, width_q);
        else if (state_q != qsm_pkg::ST_TX)
            laneOut <= 4'h0;
    end

    // Lane drivers follow the registered state only
    always_comb
    begin
        laneOeN = qsm_pkg::OEN_OFF;
        if (state_q == qsm_pkg::ST_TX)
        begin
            case (width_q)
                qsm_pkg::W1: laneOeN = qsm_pkg::OEN_W1;
                qsm_pkg::W2: laneOeN = qsm_pkg::OEN_W2;
                qsm_pkg::W4: laneOeN = qsm_pkg::OEN_W4;
                default:     laneOeN = qsm_pkg::OEN_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            period_q <= qsm_pkg::PERIOD_MAX;
        else if (state_q == qsm_pkg::ST_IDLE)
            period_q <= qsm_pkg::PERIOD_MAX;
        else if (sclkRise)
            period_q <= 4'h1;
        else if (period_q != qsm_pkg::PERIOD_MAX)
            period_q <= period_q + 4'h1;
    end

    // =====================================================================
    // APB slave, zero wait states
    // =====================================================================
    assign apbWrite = psel & penable & pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & err_q;

    // Sticky overspeed flag; a new event wins over a software clear
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            overspeed_q <= 1'b0;
        else if (sclkRise && state_q != qsm_pkg::ST_IDLE &&
                 period_q < (ddr_q ? qsm_pkg::DDR_MIN_CYC
                                   : qsm_pkg::SDR_MIN_CYC))
            overspeed_q <= 1'b1;
        else if (apbWrite && paddr == qsm_pkg::ADDR_STAT &&
                 pwdata[qsm_pkg::STAT_OVSPD])
            overspeed_q <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg1_q   <= qsm_pkg::CFG_RST;
            cfg2_q   <= qsm_pkg::CFG_RST;
            txByte_q <= qsm_pkg::BYTE_RST;
        end
        else if (apbWrite)
        begin
            case (paddr)
                qsm_pkg::ADDR_CFG1: cfg1_q   <= pwdata[7:0];
                qsm_pkg::ADDR_CFG2: cfg2_q   <= pwdata[7:0];
                qsm_pkg::ADDR_TX:   txByte_q <= pwdata[7:0];
                default:            cfg1_q   <= cfg1_q;
            endcase
        end
    end

    // Read mux; unused bits read as zero
    always_comb
    begin
        rdData = 32'h0000_0000;
        case (paddr)
            qsm_pkg::ADDR_CFG1: rdData[7:0] = cfg1_q;
            qsm_pkg::ADDR_CFG2: rdData[7:0] = cfg2_q;
            qsm_pkg::ADDR_TX:   rdData[7:0] = txByte_q;
            qsm_pkg::ADDR_RX:   rdData[7:0] = rxByte_q;
            qsm_pkg::ADDR_STAT:
            begin
                rdData[qsm_pkg::STAT_BUSY]  = (state_q != qsm_pkg::ST_IDLE);
                rdData[qsm_pkg::STAT_OVSPD] = overspeed_q;
                rdData[qsm_pkg::STAT_WP]    = wpActive;
                rdData[qsm_pkg::STAT_QPINS] = quadPins;
                rdData[qsm_pkg::STAT_WIDTH +: 3] = width_q;
                rdData[qsm_pkg::STAT_DDR]   = ddr_q;
            end
            default: rdData = 32'h0000_0000;
        endcase
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
            err_q  <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= rdData;
            err_q  <= !(paddr == qsm_pkg::ADDR_CFG1 ||
                        paddr == qsm_pkg::ADDR_CFG2 ||
                        paddr == qsm_pkg::ADDR_TX   ||
                        paddr == qsm_pkg::ADDR_RX   ||
                        paddr == qsm_pkg::ADDR_STAT);
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_lanes_released: assert property (
        (state_q != qsm_pkg::ST_TX) |-> (laneOeN == qsm_pkg::OEN_OFF))
        else $error("lane driven outside read data");
    a_si_input_only: assert property (
        (width_q == qsm_pkg::W1) |-> laneOeN[0])
        else $error("lane 0 driven in single mode");
    a_so_drives: assert property (
        (state_q == qsm_pkg::ST_TX && width_q == qsm_pkg::W1)
        |-> (!laneOeN[1] && laneOeN[3:2] == 2'h3))
        else $error("lane 1 not driving single read");
    a_dual_lanes: assert property (
        (state_q == qsm_pkg::ST_TX && width_q == qsm_pkg::W2)
        |-> (laneOeN == qsm_pkg::OEN_W2))
        else $error("dual read lane enables wrong");
    a_quad_lanes: assert property (
        (state_q == qsm_pkg::ST_TX && width_q == qsm_pkg::W4)
        |-> (laneOeN == qsm_pkg::OEN_W4 && quadPins))
        else $error("quad read without all lanes");
    a_wp_blocks: assert property (
        wpActive |=> $stable(rxByte_q))
        else $error("write landed under write protect");
    a_reset_pin: assert property (
        (hwReset && state_q != qsm_pkg::ST_IDLE) |=>
        (state_q == qsm_pkg::ST_IDLE))
        else $error("reset pin did not end frame");
    a_opcode_sdr: assert property (
        (state_q == qsm_pkg::ST_OPC) |-> !ddr_q)
        else $error("double rate during opcode");
    a_ddr_quad_only: assert property (
        ddr_q |-> (width_q == qsm_pkg::W4 && state_q != qsm_pkg::ST_IDLE))
        else $error("double rate outside quad data");
    a_mode_persist: assert property (
        !(apbWrite && paddr == qsm_pkg::ADDR_CFG2) |=> $stable(cfg2_q))
        else $error("mode bits changed without write");
    a_reset_lane_data: assert property (
        (quadPins && !pinsSync.lanes[3] && state_q == qsm_pkg::ST_TX &&
         !pinsSync.csN) |=> (state_q == qsm_pkg::ST_TX))
        else $error("lane 3 acted as reset in quad");

endmodule // qsm_port

`default_nettype wire

// ===== qsm_pkg.sv
// Purpose: Shared constants and types for the quad serial memory port.
// Assumes: System clock of 125 MHz; APB register access, one word each.
// Notes:   Opcode values and register offsets are local choices.

`default_nettype none

package qsm_pkg;

    // =====================================================================
    // Clocking and link rate limits
    // =====================================================================
    localparam int unsigned CLK_KHZ      = 125000;
    localparam int unsigned SDR_FMAX_KHZ = 108000;
    localparam int unsigned DDR_FMAX_KHZ = 54000;
    // Shortest legal serial clock period in system cycles, rounded down so
    // that sampling jitter of one cycle never raises a false alarm
    localparam logic [3:0] SDR_MIN_CYC =
        4'(((CLK_KHZ / SDR_FMAX_KHZ) < 1) ? 1 : (CLK_KHZ / SDR_FMAX_KHZ));
    localparam logic [3:0] DDR_MIN_CYC =
        4'(((CLK_KHZ / DDR_FMAX_KHZ) < 1) ? 1 : (CLK_KHZ / DDR_FMAX_KHZ));
    localparam logic [3:0] PERIOD_MAX  = 4'hF;

    // =====================================================================
    // APB register map
    // =====================================================================
    localparam int unsigned ADDR_W    = 8;
    localparam logic [7:0]  ADDR_CFG1 = 8'h00;
    localparam logic [7:0]  ADDR_CFG2 = 8'h04;
    localparam logic [7:0]  ADDR_TX   = 8'h08;
    localparam logic [7:0]  ADDR_RX   = 8'h0C;
    localparam logic [7:0]  ADDR_STAT = 8'h10;
    localparam logic [7:0]  CFG_RST   = 8'h00;
    localparam logic [7:0]  BYTE_RST  = 8'h00;

    // Field positions
    localparam int unsigned CFG1_QUAD_EN = 1;
    localparam int unsigned CFG2_DUAL    = 4;
    localparam int unsigned CFG2_QUAD    = 6;
    localparam int unsigned STAT_BUSY    = 0;
    localparam int unsigned STAT_OVSPD   = 1;
    localparam int unsigned STAT_WP      = 2;
    localparam int unsigned STAT_QPINS   = 3;
    localparam int unsigned STAT_WIDTH   = 4;
    localparam int unsigned STAT_DDR     = 7;

    // =====================================================================
    // Lane widths, coded so that the value is the bit count per edge
    // =====================================================================
    typedef logic [2:0] qsm_width_t;
    localparam qsm_width_t W1 = 3'h1;
    localparam qsm_width_t W2 = 3'h2;
    localparam qsm_width_t W4 = 3'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Lane output enables, active low
    localparam logic [3:0] OEN_OFF = 4'hF;
    localparam logic [3:0] OEN_W1  = 4'hD;
    localparam logic [3:0] OEN_W2  = 4'hC;
    localparam logic [3:0] OEN_W4  = 4'h0;

    // =====================================================================
    // Opcodes
    // =====================================================================
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_WRITE     = 8'h02;
    localparam logic [7:0] OP_DUAL_RD   = 8'h3B;
    localparam logic [7:0] OP_QUAD_RD   = 8'h6B;
    localparam logic [7:0] OP_QUAD_WR   = 8'h32;
    localparam logic [7:0] OP_DDR_RD    = 8'hED;
    localparam logic [7:0] OP_DDR_WR    = 8'hDE;

    // Decoded command
    typedef struct packed {
        logic       ok;
        logic       rd;
        logic       ddr;
        qsm_width_t width;
    } qsm_cmd_t;

    // Link pins as sampled
    typedef struct packed {
        logic       sclk;
        logic       csN;
        logic [3:0] lanes;
    } qsm_pins_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_OPC  = 5'h02,
        ST_RX   = 5'h04,
        ST_TX   = 5'h08,
        ST_SKIP = 5'h10
    } qsm_state_t;

endpackage

`default_nettype wire

// ===== qsm_sync.sv
// Purpose: Two-stage synchroniser for the link pins.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   Only the second stage is visible outside.

`timescale 1ns/100ps
`default_nettype none

module qsm_sync #(
    parameter int unsigned W = 6
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds the second and nothing else
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // qsm_sync

`default_nettype wire

// ===== qsm_host_model.sv
// Purpose: Behavioural host that masters the serial link.
// Assumes: Mode 0 framing; link clock period 125 ns.
// Notes:   Released lanes toggle in dual and quad SDR reads; single reads hold lane 1 low, DDR reads hold the last opcode nibble.
`timescale 1ns/100ps
`default_nettype none
module qsm_host_model (
    input  wire logic       protN,
    input  wire logic [3:0] laneOut,
    input  wire logic [3:0] laneOeN,
    output var  logic       sclk,
    output var  logic       csN,
    output var  logic [3:0] laneIn
);
    logic [3:0] hostDrv;
    // =======
    // Wire level: the device wins wherever its enable is low
    assign laneIn = (laneOut & ~laneOeN) | (hostDrv & laneOeN);
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        hostDrv = 4'hC;
    end
    // 8 MHz clock, single rate, opcode included
    task automatic shift(input int w, input logic [7:0] b,
                         input bit rd, output logic [7:0] got);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        got = 8'h00;
        for (int k = 8 - w; k >= 0; k -= w)
        begin
            hostDrv = ((rd ? ~hostDrv : 4'(b >> k)) & m)
                      | ({1'b1, protN, 2'h0} & ~m);
            #62.5 sclk = 1'b1;
            // Single rate reads come back on lane 1, wider ones from lane 0 upward
            got = (got << w) |
                  {4'h0, ((w == 1) ? {3'h0, laneIn[1]} : (laneIn & m))};
            #62.5 sclk = 1'b0;
        end
    endtask
    // double rate read, one nibble per link clock edge
    task automatic ddr_read(output logic [7:0] got);
        #62.5 sclk = 1'b1;
        got[7:4] = laneIn;
        #62.5 sclk = 1'b0;
        got[3:0] = laneIn;
    endtask
    // quad opcodes go out only after quad enable is set
    task automatic frame(input int ow, dw, input logic [7:0] op, dat,
                         input bit rd, output logic [7:0] got);
        logic [7:0] nul;
        // Fractional offset keeps link edges clear of clk_sys edges
        #0.3 csN = 1'b0;
        #125 shift(ow, op, 1'b0, nul);
        // A data width of 0 selects a quad double rate read
        if (dw == 0)
            ddr_read(got);
        else
            shift(dw, dat, rd, got);
        #62.5 csN = 1'b1;
        #250 hostDrv = {1'b1, protN, 2'h1};
    endtask
endmodule // qsm_host_model
`default_nettype wire

// ===== qsm_tb.sv
// Purpose: Self-checking bench for the serial memory port.
// Assumes: APB master here, link master in the host model.
// Notes:   Each read frame returns the TX byte; RX shows host writes.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic protN = 1, pready, pslverr, err, sclk, csN;
    logic [7:0] paddr = 8'h00, got;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] laneIn, laneOut, laneOeN;
    int mismatches = 0, num_checks = 0;
    always #4 clk_sys = ~clk_sys;
    qsm_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .csN(csN), .laneIn(laneIn),
        .laneOut(laneOut), .laneOeN(laneOeN));
    qsm_host_model hst (.protN(protN), .laneOut(laneOut),
        .laneOeN(laneOeN), .sclk(sclk), .csN(csN), .laneIn(laneIn));
    // =======
    // One APB transfer; waits for pready, no cycle count assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog: the tests need about 15 us
    initial
    begin
        #100000 mismatches++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk("status reset", 32'h10, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, 8'h08, 32'hA5);
        apb(1'b0, 8'h08, 32'h0);
        chk("tx readback", 32'hA5, rd);
        $display("test registers done");
        hst.frame(1, 1, 8'h02, 8'h3C, 1'b0, got);
        apb(1'b0, 8'h0C, 32'h0);
        chk("single write", 32'h3C, rd);
        hst.frame(1, 1, 8'h03, 8'h00, 1'b1, got);
        chk("single read", 32'hA5, {24'h0, got});
        chk("lanes released", 32'hF, {28'h0, laneOeN});
        protN <= 1'b0;
        hst.frame(1, 1, 8'h02, 8'h11, 1'b0, got);
        apb(1'b0, 8'h0C, 32'h0);
        chk("protected write", 32'h3C, rd);
        protN <= 1'b1;
        hst.frame(1, 2, 8'h3B, 8'h00, 1'b1, got);
        chk("dual read", 32'hA5, {24'h0, got});
        $display("test single and dual done");
        apb(1'b1, 8'h00, 32'h2);
        hst.frame(1, 4, 8'h6B, 8'h00, 1'b1, got);
        chk("quad read", 32'hA5, {24'h0, got});
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h40);
        hst.frame(4, 4, 8'h03, 8'h00, 1'b1, got);
        chk("quad channel", 32'hA5, {24'h0, got});
        apb(1'b0, 8'h04, 32'h0);
        chk("mode kept", 32'h40, rd);
        hst.frame(4, 0, 8'hED, 8'h00, 1'b1, got);
        chk("ddr read", 32'hA5, {24'h0, got});
        apb(1'b1, 8'h04, 32'h10);
        hst.frame(2, 2, 8'h03, 8'h00, 1'b1, got);
        chk("dual channel", 32'hA5, {24'h0, got});
        $display("test quad done");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
